/* File: dv/host_bus_model.sv */
// Host model that issues register bus writes and reads toward the command decoder.
`timescale 1ns/1ns
`default_nettype none

module host_bus_model (
  input  wire logic                         ref_clk,
  output var  cmd_decoder_pkg::bus_req_type bus_req,
  input  wire logic [7:0]                   rd_data
);
  import cmd_decoder_pkg::*;

  initial begin
    bus_req = '0;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Address and data stay put after the strobe drops, so a late sample never sees a stray value.
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    data = rd_data;
  endtask
endmodule

`default_nettype wire

/* File: dv/serial_channel_command_decoder_test.sv */
// Self-checking bench for the serial channel command decoder.
`timescale 1ns/1ns
`default_nettype none

module serial_channel_command_decoder_test;
  import cmd_decoder_pkg::*;

  localparam int RX_OFF = 13, UNDERRUN = 12, CRC_START = 11, TX_LOAD = 9;
  localparam int RX_STORED = 8, RX_SPECIAL = 6;

  logic         ref_clk;
  logic         rst_b;
  bus_req_type  bus_req;
  logic [7:0]   rd_data;
  chan_evt_type evt;
  chan_act_type act;
  chan_act_type acc;
  logic [3:0]   reg_pointer;
  logic         shift_left;
  logic [3:0]   ptr_nm;
  logic         sl_nm;
  logic         ext_int_req;
  logic         rx_int_req;
  logic         tx_int_req;
  logic [7:0]   d;
  int           n_errors;
  int           checks;
  int           n_ones;

  serial_channel_command_decoder serial_channel_command_decoder_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .chan_evt(evt), .chan_act(act), .reg_pointer(reg_pointer), .shift_left(shift_left),
    .ext_int_req(ext_int_req), .rx_int_req(rx_int_req), .tx_int_req(tx_int_req));

  serial_channel_command_decoder #(.MUX_BUS(1'b0)) serial_channel_command_decoder_nomux_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(),
    .chan_evt(evt), .chan_act(), .reg_pointer(ptr_nm), .shift_left(sl_nm),
    .ext_int_req(), .rx_int_req(), .tx_int_req());

  host_bus_model host_bus_model_inst (
    .ref_clk(ref_clk), .bus_req(bus_req), .rd_data(rd_data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Action pulses last one cycle and abort_ones lasts eight, so every cycle is sampled, collected and its ones counted.
  task automatic run(input int n);
    acc = '0;
    n_ones = 0;
    repeat (n) begin
      #1;
      acc = acc | act;
      n_ones += int'(act.abort_ones);
      @(posedge ref_clk);
    end
  endtask

  task automatic pulse(input int pos);
    chan_evt_type p;
    p = '0;
    p[pos] = 1'b1;
    @(posedge ref_clk);
    evt <= evt | p;
    @(posedge ref_clk);
    evt <= evt & ~p;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] b);
    host_bus_model_inst.write_reg(a, b);
  endtask

  task automatic cmd(input logic [7:0] b);
    host_bus_model_inst.write_reg(CMD_REG_ADDR, b);
  endtask

  task automatic rd(input logic [3:0] a);
    host_bus_model_inst.read_reg(a, d);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    evt = '0;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    run(1);
    check(8'({ext_int_req, rx_int_req, tx_int_req}), 8'h00);
    rd(STATUS_REG_ADDR);
    check(8'(d[7]), 8'h01);
    rd(4'hF);
    check(d, 8'h00);
    cmd(8'h03);
    run(3);
    check(8'(acc != '0), 8'h00);
    check(8'(reg_pointer), 8'h03);
    check(8'({ptr_nm, sl_nm}), 8'h01);
    check(8'(shift_left), 8'h00);
    cmd(8'h0F);
    run(2);
    check(8'(reg_pointer), 8'h0F);
    @(posedge ref_clk);
    evt.tx_enabled <= 1'b1;
    cmd(8'h8C);
    run(3);
    check(8'({acc.tx_crc_init, acc.rx_crc_init}), 8'h02);
    check(8'(reg_pointer), 8'h0C);
    check(8'({ptr_nm, sl_nm}), 8'h00);
    cmd(8'h40);
    run(3);
    check(8'(acc.rx_crc_init), 8'h01);
    pulse(RX_OFF);
    run(3);
    check(8'(acc.rx_crc_init), 8'h01);
    cmd(8'hC0);
    rd(STATUS_REG_ADDR);
    check(8'(d[7]), 8'h00);
    pulse(UNDERRUN);
    run(4);
    check(8'({acc.append_crc, acc.send_abort_flag}), 8'h02);
    pulse(CRC_START);
    rd(STATUS_REG_ADDR);
    check(8'(d[7]), 8'h01);
    pulse(UNDERRUN);
    run(4);
    check(8'(acc.append_crc), 8'h00);
    @(posedge ref_clk);
    evt.sdlc_mode <= 1'b1;
    evt.abort_on_underrun <= 1'b1;
    cmd(8'hC0);
    pulse(UNDERRUN);
    run(4);
    check(8'({acc.append_crc, acc.send_abort_flag}), 8'h01);
    cmd(8'h18);
    run(14);
    check(8'(n_ones), 8'h08);
    check(8'(acc.tx_buf_flush), 8'h01);
    rd(STATUS_REG_ADDR);
    check(8'(d[7]), 8'h01);
    // With the transmitter off the latch reset only reports through the status interrupt.
    @(posedge ref_clk);
    evt <= '0;
    wr(CONTROL_REG_ADDR, 8'h01);
    rd(CONTROL_REG_ADDR);
    check(d, 8'h01);
    cmd(8'hC0);
    run(3);
    check(8'(ext_int_req), 8'h01);
    rd(STATUS_REG_ADDR);
    check(8'(d[7]), 8'h01);
    cmd(8'h10);
    run(3);
    check(8'(ext_int_req), 8'h00);
    @(posedge ref_clk);
    evt.ext_level <= 1'b1;
    run(3);
    check(8'(ext_int_req), 8'h01);
    @(posedge ref_clk);
    evt.ext_level <= 1'b0;
    @(posedge ref_clk);
    evt.ext_level <= 1'b1;
    cmd(8'h10);
    run(3);
    check(8'(ext_int_req), 8'h00);
    @(posedge ref_clk);
    evt.ext_level <= 1'b0;
    run(3);
    @(posedge ref_clk);
    evt.ext_level <= 1'b1;
    run(2);
    cmd(8'h10);
    run(3);
    check(8'(ext_int_req), 8'h01);
    @(posedge ref_clk);
    evt.rx_int_mode <= RX_INT_FIRST;
    cmd(8'h20);
    pulse(RX_STORED);
    #1;
    check(8'(rx_int_req), 8'h01);
    run(2);
    pulse(RX_SPECIAL);
    cmd(8'h30);
    run(3);
    check(8'({acc.rx_err_clear, acc.rx_discard}), 8'h03);
    wr(CONTROL_REG_ADDR, 8'h02);
    cmd(8'h28);
    rd(STATUS_REG_ADDR);
    check(8'({d[2], tx_int_req}), 8'h02);
    pulse(TX_LOAD);
    rd(STATUS_REG_ADDR);
    check(8'(d[2]), 8'h00);
    @(posedge ref_clk);
    evt.ius_bits <= 3'b110;
    cmd(8'h38);
    run(3);
    check(8'(acc.ius_clear), 8'h02);
    report_and_stop();
  end
endmodule

`default_nettype wire

/* File: verilog/cmd_decoder_pkg.sv */
// Package with the command byte layout, codes and status types of the command decoder.
package cmd_decoder_pkg;

  // ****************************************************************
  // Command byte fields
  // ****************************************************************
  localparam int CRC_FIELD_MSB = 7;
  localparam int CRC_FIELD_LSB = 6;
  localparam int CMD_FIELD_MSB = 5;
  localparam int CMD_FIELD_LSB = 3;
  localparam int PTR_FIELD_MSB = 2;
  localparam int PTR_FIELD_LSB = 0;
  localparam int SHIFT_SEL_BIT = 0;
  localparam int PTR_WIDTH     = 4;

  // ****************************************************************
  // Register addresses and reset values
  // ****************************************************************
  localparam logic [3:0] CMD_REG_ADDR     = 4'h0;
  localparam logic [3:0] STATUS_REG_ADDR  = 4'h1;
  localparam logic [3:0] CONTROL_REG_ADDR = 4'h2;
  localparam logic [3:0] UPPER_BANK_OFS   = 4'h8;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [3:0] ABORT_ONES       = 4'h8;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [1:0] CRC_NULL       = 2'b00;
  localparam logic [1:0] CRC_RX_RESET   = 2'b01;
  localparam logic [1:0] CRC_TX_RESET   = 2'b10;
  localparam logic [1:0] CRC_LATCH_RST  = 2'b11;
  localparam logic [2:0] CMD_NULL       = 3'b000;
  localparam logic [2:0] CMD_POINT_HIGH = 3'b001;
  localparam logic [2:0] CMD_EXT_RESET  = 3'b010;
  localparam logic [2:0] CMD_SEND_ABORT = 3'b011;
  localparam logic [2:0] CMD_RX_REARM   = 3'b100;
  localparam logic [2:0] CMD_TX_IP_RST  = 3'b101;
  localparam logic [2:0] CMD_ERR_RESET  = 3'b110;
  localparam logic [2:0] CMD_IUS_RESET  = 3'b111;

  localparam logic [1:0] RX_INT_OFF     = 2'b00;
  localparam logic [1:0] RX_INT_FIRST   = 2'b01;
  localparam logic [1:0] RX_INT_ALL     = 2'b10;
  localparam logic [1:0] RX_INT_SPECIAL = 2'b11;

  // Register bus request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  // Events coming from the rest of the channel.
  typedef struct packed {
    logic       sdlc_mode;
    logic       abort_on_underrun;
    logic       tx_enabled;
    logic       rx_disable;
    logic       tx_underrun;
    logic       crc_send_start;
    logic       crc_send_done;
    logic       tx_char_loaded;
    logic       rx_char_stored;
    logic       rx_fifo_read;
    logic       rx_special;
    logic [1:0] rx_int_mode;
    logic [2:0] ius_bits;
    logic       ext_level;
  } chan_evt_type;

  // Actions issued to the rest of the channel.
  typedef struct packed {
    logic       rx_crc_init;
    logic       tx_crc_init;
    logic       append_crc;
    logic       send_abort_flag;
    logic       abort_ones;
    logic       tx_buf_flush;
    logic       rx_discard;
    logic       rx_err_clear;
    logic [2:0] ius_clear;
  } chan_act_type;

  typedef enum logic [2:0] {
    ABORT_IDLE = 3'b001,
    ABORT_SEND = 3'b010,
    ABORT_DONE = 3'b100
  } abort_state_type;

endpackage

/* File: verilog/serial_channel_command_decoder.sv */
// Command byte decoder for one serial channel.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module serial_channel_command_decoder #(
  parameter bit MUX_BUS = 1'b1
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  input  wire cmd_decoder_pkg::bus_req_type  bus_req,
  output var  logic [7:0]                    rd_data,
  input  wire cmd_decoder_pkg::chan_evt_type chan_evt,
  output var  cmd_decoder_pkg::chan_act_type chan_act,
  output var  logic [3:0]                    reg_pointer,
  output var  logic                          shift_left,
  output var  logic                          ext_int_req,
  output var  logic                          rx_int_req,
  output var  logic                          tx_int_req
);
  import cmd_decoder_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic       cmd_wr     = bus_req.wr && (bus_req.addr == CMD_REG_ADDR);
  wire logic       ctl_wr     = bus_req.wr && (bus_req.addr == CONTROL_REG_ADDR);
  wire logic [1:0] crc_field  = bus_req.wdata[CRC_FIELD_MSB:CRC_FIELD_LSB];
  wire logic [2:0] cmd_field  = bus_req.wdata[CMD_FIELD_MSB:CMD_FIELD_LSB];
  wire logic [2:0] ptr_field  = bus_req.wdata[PTR_FIELD_MSB:PTR_FIELD_LSB];
  // Each field is decoded on its own so one write may carry all three.
  wire logic do_rx_crc   = cmd_wr && (crc_field == CRC_RX_RESET);
  wire logic do_tx_crc   = cmd_wr && (crc_field == CRC_TX_RESET);
  wire logic do_latch    = cmd_wr && (crc_field == CRC_LATCH_RST);
  wire logic do_ext_rst  = cmd_wr && (cmd_field == CMD_EXT_RESET);
  wire logic do_abort    = cmd_wr && (cmd_field == CMD_SEND_ABORT);
  wire logic do_rearm    = cmd_wr && (cmd_field == CMD_RX_REARM);
  wire logic do_tx_ip    = cmd_wr && (cmd_field == CMD_TX_IP_RST);
  wire logic do_err      = cmd_wr && (cmd_field == CMD_ERR_RESET);
  wire logic do_ius      = cmd_wr && (cmd_field == CMD_IUS_RESET);
  wire logic point_high  = cmd_wr && (cmd_field == CMD_POINT_HIGH);
  wire logic holding_mode = (chan_evt.rx_int_mode == RX_INT_FIRST) ||
                            (chan_evt.rx_int_mode == RX_INT_SPECIAL);

  // ****************************************************************
  // State
  // ****************************************************************
  logic            latch_reg;
  logic            ext_pend_reg;
  logic            ext_snap_reg;
  logic            ext_change_reg;
  logic            rx_armed_reg;
  logic            rx_held_reg;
  logic            tx_hold_reg;
  logic            underrun_seen_reg;
  logic [7:0]      control_reg;
  logic [3:0]      abort_cnt_reg;
  abort_state_type abort_state_reg;
  abort_state_type abort_state_next;

  // Latch clear only with the transmitter running; CRC start sets it.
  wire logic latch_clear = do_latch && chan_evt.tx_enabled;
  wire logic latch_next  = chan_evt.crc_send_start || do_abort ||
                           (latch_reg && !latch_clear);

  // A disabled-transmitter latch reset still reports once through the status path.
  wire logic latch_ext_evt = do_latch && !chan_evt.tx_enabled &&
                             (!ext_pend_reg || do_ext_rst);

  // Changes seen while pending are compared again at release time.
  wire logic level_diff   = chan_evt.ext_level != ext_snap_reg;
  wire logic ext_pend_next = latch_ext_evt ||
                             (do_ext_rst ? level_diff : (ext_pend_reg || level_diff));

  // Underrun with a clear latch closes the frame by CRC or by abort.
  wire logic underrun_act = chan_evt.tx_underrun && !latch_reg;
  wire logic use_abort    = chan_evt.sdlc_mode && chan_evt.abort_on_underrun;

  // Release leaves the held character in place once the host has read it.
  wire logic rx_discard_next = do_err && holding_mode && rx_held_reg;
  wire logic rx_held_next = holding_mode && !do_err &&
                            ((chan_evt.rx_special && !chan_evt.rx_fifo_read) ||
                             (rx_held_reg && !chan_evt.rx_fifo_read));

  // Lowest set index is the highest priority under service.
  wire logic [2:0] ius_low = chan_evt.ius_bits & (~chan_evt.ius_bits + 3'b001);

  wire logic [3:0] ptr_next = point_high ? ({1'b0, ptr_field} + UPPER_BANK_OFS)
                                         : {1'b0, ptr_field};

  // ****************************************************************
  // Abort sequence
  // ****************************************************************
  always_comb begin
    abort_state_next = abort_state_reg;
    unique case (abort_state_reg)
      ABORT_IDLE: begin
        if (do_abort && chan_evt.sdlc_mode) begin
          abort_state_next = ABORT_SEND;
        end
      end
      ABORT_SEND: begin
        if (abort_cnt_reg == 4'h1) begin
          abort_state_next = ABORT_DONE;
        end
      end
      ABORT_DONE: begin
        abort_state_next = ABORT_IDLE;
      end
      default: begin
        abort_state_next = ABORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_state_reg <= ABORT_IDLE;
      abort_cnt_reg   <= 4'h0;
    end else begin
      abort_state_reg <= abort_state_next;
      if (abort_state_reg == ABORT_IDLE) begin
        abort_cnt_reg <= ABORT_ONES;
      end else if (abort_cnt_reg != 4'h0) begin
        abort_cnt_reg <= abort_cnt_reg - 4'h1;
      end
    end
  end

  // ****************************************************************
  // Latches and flags
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_reg         <= 1'b1;
      ext_pend_reg      <= 1'b0;
      ext_snap_reg      <= 1'b0;
      ext_change_reg    <= 1'b0;
      rx_armed_reg      <= 1'b0;
      rx_held_reg       <= 1'b0;
      tx_hold_reg       <= 1'b0;
      underrun_seen_reg <= 1'b0;
      control_reg       <= CONTROL_RESET;
    end else begin
      latch_reg <= latch_next;
      ext_pend_reg <= ext_pend_next;
      if (!ext_pend_reg || do_ext_rst) begin
        ext_snap_reg <= chan_evt.ext_level;
      end
      ext_change_reg <= level_diff;
      // Set wins: a new character in the same cycle keeps the request alive.
      rx_armed_reg <= do_rearm || (rx_armed_reg && !chan_evt.rx_char_stored);
      rx_held_reg <= rx_held_next;
      tx_hold_reg <= do_tx_ip ||
                     (tx_hold_reg && !chan_evt.tx_char_loaded && !chan_evt.crc_send_done);
      underrun_seen_reg <= underrun_act || (underrun_seen_reg && !do_latch);
      if (ctl_wr) begin
        control_reg <= bus_req.wdata;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_act    <= '0;
      reg_pointer <= 4'h0;
      shift_left  <= 1'b0;
      ext_int_req <= 1'b0;
      rx_int_req  <= 1'b0;
      tx_int_req  <= 1'b0;
      rd_data     <= 8'h00;
    end else begin
      chan_act.rx_crc_init <= do_rx_crc || chan_evt.rx_disable ||
                              (chan_evt.sdlc_mode && chan_evt.crc_send_done);
      chan_act.tx_crc_init     <= do_tx_crc;
      chan_act.append_crc      <= underrun_act && !use_abort;
      chan_act.send_abort_flag <= underrun_act && use_abort;
      chan_act.abort_ones      <= abort_state_reg == ABORT_SEND;
      chan_act.tx_buf_flush    <= do_abort;
      chan_act.rx_discard      <= rx_discard_next;
      chan_act.rx_err_clear    <= do_err;
      chan_act.ius_clear       <= do_ius ? ius_low : 3'b000;
      if (cmd_wr && MUX_BUS) begin
        reg_pointer <= ptr_next;
      end
      if (cmd_wr && !MUX_BUS) begin
        // D2 is ignored here; D0 alone steers the shift arrangement.
        reg_pointer <= 4'h0;
        shift_left  <= bus_req.wdata[SHIFT_SEL_BIT];
      end
      ext_int_req <= ext_pend_next && control_reg[0];
      rx_int_req  <= (rx_armed_reg && chan_evt.rx_char_stored) || rx_held_next;
      tx_int_req  <= control_reg[1] && !tx_hold_reg && !chan_evt.tx_char_loaded;
      rd_data     <= 8'h00;
      if (bus_req.rd && bus_req.addr == STATUS_REG_ADDR) begin
        rd_data <= {latch_reg, ext_pend_reg, ext_change_reg, rx_armed_reg,
                    rx_held_reg, tx_hold_reg, underrun_seen_reg,
                    abort_state_reg != ABORT_IDLE};
      end else if (bus_req.rd && bus_req.addr == CONTROL_REG_ADDR) begin
        rd_data <= control_reg;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_tx_crc_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_tx_crc |=> chan_act.tx_crc_init)
    else $error("transmit CRC init missing");
  a_latch_hold_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (do_latch && !chan_evt.tx_enabled && latch_reg && !do_abort) |=> latch_reg)
    else $error("latch cleared with transmitter off");
  a_latch_set_crc: assert property (@(posedge ref_clk) disable iff (!rst_b)
    chan_evt.crc_send_start |=> latch_reg)
    else $error("latch not set at CRC start");
  a_point_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (point_high && MUX_BUS) |=> reg_pointer == $past(ptr_field) + 4'h8)
    else $error("pointer not raised by eight");
  a_abort_ones: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (do_abort && chan_evt.sdlc_mode && abort_state_reg == ABORT_IDLE)
      |=> ##1 chan_act.abort_ones [*8])
    else $error("abort ones too short");
  a_ius_onehot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $countones(chan_act.ius_clear) <= 1)
    else $error("more than one service bit cleared");
  a_underrun_crc: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (underrun_act && use_abort) |=> !chan_act.append_crc && chan_act.send_abort_flag)
    else $error("CRC sent instead of abort");
  a_err_discard: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (do_err && holding_mode && rx_held_reg) |=> chan_act.rx_discard && !rx_held_reg)
    else $error("held character not discarded");

  // ****************************************************************
  // Checks on the CRC reset field
  // ****************************************************************
  // The null code must stay silent, otherwise pointer-only writes would disturb a frame.
  a_null_crc_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_wr && crc_field == CRC_NULL && !chan_evt.rx_disable && !chan_evt.sdlc_mode)
      |=> !chan_act.rx_crc_init && !chan_act.tx_crc_init)
    else $error("null code started a CRC action");
  a_rx_crc_cmd: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_rx_crc |=> chan_act.rx_crc_init)
    else $error("receive CRC init missing");
  a_rx_crc_disable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    chan_evt.rx_disable |=> chan_act.rx_crc_init)
    else $error("receiver disable left CRC checker alone");
  a_rx_crc_sdlc: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (chan_evt.sdlc_mode && chan_evt.crc_send_done) |=> chan_act.rx_crc_init)
    else $error("automatic receive CRC init missing");
  a_tx_crc_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !do_tx_crc |=> !chan_act.tx_crc_init)
    else $error("transmit CRC init without command");

  // ****************************************************************
  // Checks on the underrun latch
  // ****************************************************************
  a_latch_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (latch_clear && !chan_evt.crc_send_start && !do_abort) |=> !latch_reg)
    else $error("latch reset ignored");
  a_append_crc: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (underrun_act && !use_abort) |=> chan_act.append_crc)
    else $error("CRC not appended on underrun");
  a_latch_blocks: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (chan_evt.tx_underrun && latch_reg)
      |=> !chan_act.append_crc && !chan_act.send_abort_flag)
    else $error("underrun acted with latch set");
  a_frame_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !underrun_act |=> !chan_act.send_abort_flag && !chan_act.append_crc)
    else $error("frame end without underrun");
  a_latch_stays: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (latch_reg && !latch_clear) |=> latch_reg)
    else $error("latch dropped without reset");
  a_latch_ext_irq: assert property (@(posedge ref_clk) disable iff (!rst_b)
    latch_ext_evt |=> ext_pend_reg)
    else $error("latch reset not reported");

  // ****************************************************************
  // Checks on the pointer
  // ****************************************************************
  a_ptr_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_wr && MUX_BUS && !point_high) |=> reg_pointer == {1'b0, $past(ptr_field)})
    else $error("pointer not loaded");
  a_ptr_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !cmd_wr |=> $stable(reg_pointer))
    else $error("pointer moved without write");
  a_nomux_ptr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_wr && !MUX_BUS)
      |=> reg_pointer == 4'h0 && shift_left == $past(bus_req.wdata[SHIFT_SEL_BIT]))
    else $error("shift selection wrong");
  a_fields_together: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (do_tx_crc && point_high && MUX_BUS) |=> chan_act.tx_crc_init && reg_pointer[3])
    else $error("fields of one byte not all acted on");

  // ****************************************************************
  // Checks on external status
  // ****************************************************************
  a_ext_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ext_pend_reg && !do_ext_rst) |=> ext_pend_reg)
    else $error("status released without command");
  a_ext_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (do_ext_rst && !level_diff && !latch_ext_evt) |=> !ext_pend_reg)
    else $error("reverted change raised interrupt");
  a_ext_queue: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (do_ext_rst && level_diff) |=> ext_pend_reg)
    else $error("persisting change lost");

  // ****************************************************************
  // Checks on abort and transmit interrupts
  // ****************************************************************
  a_abort_flush: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_abort |=> chan_act.tx_buf_flush && latch_reg)
    else $error("abort did not flush or set latch");
  a_abort_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (abort_state_reg == ABORT_IDLE && !(do_abort && chan_evt.sdlc_mode))
      |=> abort_state_reg == ABORT_IDLE)
    else $error("abort started without command");
  a_tx_hold_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_tx_ip |=> tx_hold_reg)
    else $error("transmit hold not set");
  a_tx_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tx_hold_reg |=> !tx_int_req)
    else $error("transmit interrupt while held");
  a_tx_hold_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_hold_reg && !do_tx_ip && (chan_evt.tx_char_loaded || chan_evt.crc_send_done))
      |=> !tx_hold_reg)
    else $error("transmit hold not ended");

  // ****************************************************************
  // Checks on the receive side
  // ****************************************************************
  a_rearm: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_rearm |=> rx_armed_reg)
    else $error("receive interrupt not re-armed");
  a_rx_irq: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rx_armed_reg && chan_evt.rx_char_stored) |=> rx_int_req)
    else $error("first character gave no interrupt");
  a_rearm_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rx_armed_reg && chan_evt.rx_char_stored && !do_rearm) |=> !rx_armed_reg)
    else $error("receive arm not consumed");
  a_err_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_err |=> chan_act.rx_err_clear)
    else $error("receive errors not cleared");
  a_rx_hold_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rx_held_reg && holding_mode && !do_err && !chan_evt.rx_fifo_read) |=> rx_held_reg)
    else $error("held character released early");
  a_rx_no_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !holding_mode |=> !rx_held_reg)
    else $error("character held in wrong mode");
  a_err_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (do_err && !(holding_mode && rx_held_reg)) |=> !chan_act.rx_discard)
    else $error("character discarded without hold");

  // ****************************************************************
  // Checks on the service chain
  // ****************************************************************
  // Only the lowest set bit may go; clearing more would let a lower source jump the queue.
  a_ius_lowest: assert property (@(posedge ref_clk) disable iff (!rst_b)
    do_ius |=> chan_act.ius_clear == $past(ius_low))
    else $error("wrong service bit cleared");
  a_ius_none: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !do_ius |=> chan_act.ius_clear == 3'b000)
    else $error("service bit cleared without command");

endmodule
`default_nettype wire
